// >>> src/panel_timing_pkg.sv
package panel_timing_pkg;

    // register byte offsets on the avalon slave
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_HWIDTH = 5'h04;
    localparam logic [4:0] OFS_VCOUNT = 5'h08;
    localparam logic [4:0] OFS_MOD = 5'h0C;
    localparam logic [4:0] OFS_STATUS = 5'h10;

    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_COLOUR_BIT = 1;
    localparam int CTRL_BPP16_BIT = 2;
    localparam int HW_BLANK_LSB = 8;
    localparam int VC_BLANK_LSB = 16;
    localparam int ST_FRAME_BIT = 16;
    localparam int ST_UNDERRUN_BIT = 24;

    // reset values
    localparam logic [2:0] RST_CTRL = 3'h0;
    localparam logic [6:0] RST_ACTIVE_W = 7'h00;
    localparam logic [4:0] RST_BLANK_W = 5'h00;
    localparam logic [9:0] RST_ACTIVE_L = 10'h000;
    localparam logic [5:0] RST_BLANK_L = 6'h00;
    localparam logic [5:0] RST_MOD = 6'h00;

    // timing in source clock periods, counted in half periods
    localparam int HALVES_PER_TS = 2;
    localparam int UNIT_TS = 8;
    localparam int LINE_PW_TS = 11;
    localparam int FRAME_HOLD_TS = 12;
    localparam int AC_BASE_TS = 3;
    localparam int MONO_RISE_TS = 18;
    localparam int COLOUR_RISE_TS = 19;
    localparam int BPP16_ADJ_TS = 2;
    localparam int COLOUR_TAIL_TS = 2;

    localparam int LINE_PW_H = LINE_PW_TS * HALVES_PER_TS;
    localparam int FRAME_HOLD_H = FRAME_HOLD_TS * HALVES_PER_TS;
    localparam int AC_BASE_H = AC_BASE_TS * HALVES_PER_TS;
    localparam int UNIT_H = UNIT_TS * HALVES_PER_TS;
    localparam int MONO_RISE_H = MONO_RISE_TS * HALVES_PER_TS;
    localparam int COLOUR_RISE_H = COLOUR_RISE_TS * HALVES_PER_TS;
    localparam int BPP16_ADJ_H = BPP16_ADJ_TS * HALVES_PER_TS;
    localparam int COLOUR_TAIL_H = COLOUR_TAIL_TS * HALVES_PER_TS;

    localparam int FIFO_DEPTH = 2;
    localparam int PIX_W = 8;

endpackage

// >>> src/passive_panel_line_timing.sv
// Behaviour
// - line lasts (active width+1)*8 Ts plus (blank width+1)*8 Ts.
// - active lines per frame are the 10-bit count plus one.
// - blank lines per frame are the 6-bit count plus one.
// - frame pulse rises line period minus 12 Ts before line fall.
// - frame pulse holds 12 Ts after the line pulse falling edge.
// - ac bias toggles 3 Ts, or (blank+1)*8+3 Ts, after line fall.
// - shift clock 8 Ts period mono, 1 Ts period colour, half high.
// - mono drives all eight data bits around each shift fall.
// - colour drives only upper four data bits around shift fall.
// - first shift fall 22/20 Ts mono, 19.5/17.5 Ts colour after line.
// - first shift rise 18/16 Ts mono, 19/17 Ts colour after line.
// - mono last shift fall precedes line rise by (blank+1)*8-25/23 Ts.
// - colour last shift fall precedes line rise by (blank+1)*8-27.5/25.5 Ts.
// - last shift fall precedes line fall by (blank+1)*8 minus offset.
// - line period spans 16 Ts to 1280 Ts over the settings.
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
module passive_panel_line_timing
    import panel_timing_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic source_clock,
    input wire logic [PIX_W-1:0] pix_data,
    input wire logic pix_valid,
    output logic pix_ready,
    output logic frame_sync_pulse,
    output logic line_sync_pulse,
    output logic pixel_shift_clock,
    output logic [PIX_W-1:0] panel_pixel_bus,
    output logic panel_ac_bias,
    output logic ac_bias_alias
);

    logic ack_r;
    logic [31:0] rdata_r;
    logic enable_r, colour_r, bpp16_r;
    logic [6:0] active_w_r;
    logic [4:0] blank_w_r;
    logic [9:0] active_l_r;
    logic [5:0] blank_l_r;
    logic [5:0] mod_rate_r;
    logic underrun_r;
    logic src_s1_r, src_s2_r, src_s3_r, src_lvl_r;
    logic half_tick;
    logic [11:0] pos_r, pos_nxt;
    logic [10:0] vcnt_r, vcnt_nxt;
    logic [5:0] mcnt_r, mcnt_nxt;
    logic [11:0] line_last_h, line_rise_h, ac_h, sh_start_h, sh_end_h;
    logic [11:0] sh_off;
    logic [10:0] vcnt_last;
    logic line_active, in_window, shift_hi, shift_rise, ac_toggle;
    logic line_r, frame_r, shift_r, ac_r;
    logic [PIX_W-1:0] data_r;
    logic [PIX_W-1:0] fifo_mem [FIFO_DEPTH];
    logic wptr_r, rptr_r;
    logic [1:0] fcnt_r;
    logic push, pop, fifo_valid;
    logic acc_go, wr_go;

    // avalon slave: one wait state, request answered on second edge
    assign acc_go = (read || write) && !ack_r;
    assign wr_go = write && ack_r;
    assign waitrequest = (read || write) && !ack_r;
    assign readdata = rdata_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= acc_go;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 32'h0000_0000;
        end else if (acc_go && read) begin
            unique case (address)
                OFS_CTRL: rdata_r <= {29'h0, bpp16_r, colour_r, enable_r};
                OFS_HWIDTH: rdata_r <= {19'h0, blank_w_r, 1'b0, active_w_r};
                OFS_VCOUNT: rdata_r <= {10'h0, blank_l_r, 6'h0, active_l_r};
                OFS_MOD: rdata_r <= {26'h0, mod_rate_r};
                OFS_STATUS: rdata_r <= {7'h0, underrun_r, 7'h0, frame_r,
                                        5'h0, vcnt_r};
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {bpp16_r, colour_r, enable_r} <= RST_CTRL;
            active_w_r <= RST_ACTIVE_W;
            blank_w_r <= RST_BLANK_W;
            active_l_r <= RST_ACTIVE_L;
            blank_l_r <= RST_BLANK_L;
            mod_rate_r <= RST_MOD;
        end else if (wr_go) begin
            if (address == OFS_CTRL) begin
                enable_r <= writedata[CTRL_EN_BIT];
                colour_r <= writedata[CTRL_COLOUR_BIT];
                bpp16_r <= writedata[CTRL_BPP16_BIT];
            end
            if (address == OFS_HWIDTH) begin
                active_w_r <= writedata[6:0];
                blank_w_r <= writedata[HW_BLANK_LSB +: 5];
            end
            if (address == OFS_VCOUNT) begin
                active_l_r <= writedata[9:0];
                blank_l_r <= writedata[VC_BLANK_LSB +: 6];
            end
            if (address == OFS_MOD) begin
                mod_rate_r <= writedata[5:0];
            end
        end
    end

    // underrun is sticky; a new underrun beats a write-one clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            underrun_r <= 1'b0;
        end else if (shift_rise && half_tick && !fifo_valid) begin
            underrun_r <= 1'b1;
        end else if (wr_go && address == OFS_STATUS
                     && writedata[ST_UNDERRUN_BIT]) begin
            underrun_r <= 1'b0;
        end
    end

    // source clock: three flops, a change counts when stages two and three
    // agree; both edges are half-period ticks
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            src_s1_r <= 1'b0;
            src_s2_r <= 1'b0;
            src_s3_r <= 1'b0;
            src_lvl_r <= 1'b0;
        end else begin
            src_s1_r <= source_clock;
            src_s2_r <= src_s1_r;
            src_s3_r <= src_s2_r;
            if (src_s2_r == src_s3_r) begin
                src_lvl_r <= src_s3_r;
            end
        end
    end

    assign half_tick = enable_r && (src_s2_r == src_s3_r)
                       && (src_s3_r != src_lvl_r);

    // horizontal geometry in half source periods, and the last line number of a frame
    always_comb begin
        line_last_h = 12'((active_w_r + 8'd1 + blank_w_r + 8'd1) * UNIT_H
                          - 1);
        line_rise_h = 12'(line_last_h + 12'd1 - LINE_PW_H);
        if (mod_rate_r != 6'h00) begin
            ac_h = 12'((blank_w_r + 6'd1) * UNIT_H + AC_BASE_H);
        end else begin
            ac_h = 12'(AC_BASE_H);
        end
        sh_start_h = 12'((colour_r ? COLOUR_RISE_H : MONO_RISE_H)
                         - (bpp16_r ? BPP16_ADJ_H : 0));
        // colour stops two source periods short of the active span, so its
        // last fall keeps the wider tail before the line edges
        sh_end_h = 12'(sh_start_h + (active_w_r + 8'd1) * UNIT_H
                       - (colour_r ? COLOUR_TAIL_H : 0));
        vcnt_last = 11'(active_l_r + blank_l_r + 11'd1);
    end

    // counters advance on half ticks only
    always_comb begin
        pos_nxt = pos_r;
        vcnt_nxt = vcnt_r;
        mcnt_nxt = mcnt_r;
        if (!enable_r) begin
            pos_nxt = 12'h000;
            vcnt_nxt = 11'h000;
            mcnt_nxt = 6'h00;
        end else if (half_tick) begin
            if (pos_r == line_last_h) begin
                pos_nxt = 12'h000;
                vcnt_nxt = (vcnt_r == vcnt_last) ? 11'h000
                                                 : 11'(vcnt_r + 11'd1);
                mcnt_nxt = (mcnt_r + 6'd1 >= mod_rate_r) ? 6'h00
                                                         : 6'(mcnt_r + 6'd1);
            end else begin
                pos_nxt = 12'(pos_r + 12'd1);
            end
        end
    end

    always_comb begin
        line_active = vcnt_nxt <= 11'(active_l_r);
        sh_off = 12'(pos_nxt - sh_start_h);
        in_window = line_active && pos_nxt >= sh_start_h
                    && pos_nxt < sh_end_h;
        shift_hi = in_window && (colour_r ? !sh_off[0] : !sh_off[3]);
        shift_rise = in_window
                     && (colour_r ? !sh_off[0] : sh_off[3:0] == 4'h0);
        ac_toggle = half_tick && pos_nxt == ac_h
                    && (mod_rate_r == 6'h00 || mcnt_nxt == 6'h00);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pos_r <= 12'h000;
            vcnt_r <= 11'h000;
            mcnt_r <= 6'h00;
        end else begin
            pos_r <= pos_nxt;
            vcnt_r <= vcnt_nxt;
            mcnt_r <= mcnt_nxt;
        end
    end

    // line pulse high for the last 11 Ts of every line, blank lines too
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            line_r <= 1'b0;
        end else begin
            line_r <= enable_r && pos_nxt >= line_rise_h;
        end
    end

    // frame pulse straddles the fall that opens line zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frame_r <= 1'b0;
        end else if (!enable_r) begin
            frame_r <= 1'b0;
        end else if (half_tick && pos_nxt == 12'(FRAME_HOLD_H)) begin
            if (vcnt_nxt == vcnt_last) begin
                frame_r <= 1'b1;
            end else if (vcnt_nxt == 11'h000) begin
                frame_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ac_r <= 1'b0;
        end else if (ac_toggle) begin
            ac_r <= !ac_r;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shift_r <= 1'b0;
        end else begin
            shift_r <= enable_r && shift_hi;
        end
    end

    // data changes on the shift rise so it is valid half a period on each
    // side of the fall; an empty buffer shows zero rather than stale data
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_r <= 8'h00;
        end else if (half_tick && shift_rise) begin
            if (!fifo_valid) begin
                data_r <= 8'h00;
            end else if (colour_r) begin
                data_r <= {fifo_mem[rptr_r][7:4], 4'h0};
            end else begin
                data_r <= fifo_mem[rptr_r];
            end
        end
    end

    // two-entry buffer; the source stalls while both entries are held
    assign fifo_valid = fcnt_r != 2'd0;
    assign pix_ready = fcnt_r != 2'(FIFO_DEPTH);
    assign push = pix_valid && pix_ready;
    assign pop = half_tick && shift_rise && fifo_valid;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wptr_r <= 1'b0;
            rptr_r <= 1'b0;
            fcnt_r <= 2'd0;
        end else begin
            if (push) begin
                wptr_r <= !wptr_r;
            end
            if (pop) begin
                rptr_r <= !rptr_r;
            end
            fcnt_r <= 2'(fcnt_r + {1'b0, push} - {1'b0, pop});
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            fifo_mem[wptr_r] <= pix_data;
        end
    end

    assign frame_sync_pulse = frame_r;
    assign line_sync_pulse = line_r;
    assign pixel_shift_clock = shift_r;
    assign panel_pixel_bus = data_r;
    assign panel_ac_bias = ac_r;
    assign ac_bias_alias = ac_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_line_fall_pos: assert property ($fell(line_r) |-> pos_r == 12'h000)
        else $error("line pulse fell away from line start");
    a_line_pulse_width: assert property ($rose(line_r)
        |-> pos_r == 12'(line_last_h - 12'd21))
        else $error("line pulse width is not 11 Ts");
    a_frame_rise_pos: assert property ($rose(frame_r)
        |-> pos_r == 12'd24 && vcnt_r == vcnt_last)
        else $error("frame pulse rose at wrong place");
    a_frame_hold_end: assert property ($fell(frame_r) && enable_r
        |-> pos_r == 12'd24 && vcnt_r == 11'h000)
        else $error("frame pulse hold is not 12 Ts");
    a_ac_toggle_pos: assert property ($changed(ac_r) |-> pos_r == ac_h)
        else $error("ac bias toggled at wrong delay");
    a_shift_in_window: assert property ($rose(shift_r)
        |-> pos_r >= sh_start_h && pos_r < sh_end_h)
        else $error("shift clock rose outside the active span");
    a_blank_no_shift: assert property (vcnt_r > 11'(active_l_r)
        |-> !shift_r)
        else $error("shift clock on a blank line");
    a_colour_upper_data: assert property (colour_r && $changed(data_r)
        |-> data_r[3:0] == 4'h0)
        else $error("colour panel drove low data bits");
    a_data_at_rise: assert property ($changed(data_r)
        |-> $rose(shift_r))
        else $error("panel data changed away from shift rise");
    a_bus_one_wait: assert property ((read || write) && waitrequest
        |=> !waitrequest)
        else $error("bus answer took more than one wait state");

    c_frame_start: cover property ($rose(frame_r));
    c_colour_shift: cover property (colour_r && $rose(shift_r));
    c_fifo_full: cover property (!pix_ready);
    c_underrun: cover property ($rose(underrun_r));

endmodule

// >>> verif/panel_model.sv
module panel_model (
    input wire logic clk,
    input wire logic line_sync_pulse,
    input wire logic frame_sync_pulse,
    input wire logic pixel_shift_clock,
    input wire logic [7:0] panel_pixel_bus,
    input wire logic colour
);
    timeunit 1ns;
    timeprecision 1ns;
    int cyc = 0;
    int t_chg = 0;
    int t_fall = -99;
    int errs = 0;
    int n_cap = 0;
    int lines = 0;
    int frame_lines = 0;
    int half;
    logic [7:0] cap [0:1023];
    logic sh_q = 1'h0;
    logic ln_q = 1'h0;
    logic fr_q = 1'h0;
    logic [7:0] bus_q = 8'h00;
    // the panel latches on the shift fall, so data must stand half a period
    // on each side of it; time is kept in system clocks, 8 per source period
    always @(posedge clk) begin
        half = colour ? 4 : 32;
        cyc++;
        if (panel_pixel_bus !== bus_q) begin
            if (cyc - t_fall < half) errs++;
            t_chg = cyc;
        end
        if (sh_q && !pixel_shift_clock) begin
            if (cyc - t_chg < half) errs++;
            t_fall = cyc;
            cap[n_cap] = panel_pixel_bus;
            n_cap++;
        end
        if (ln_q && !line_sync_pulse) lines++;
        if (!fr_q && frame_sync_pulse) begin
            frame_lines = lines;
            lines = 0;
        end
        sh_q = pixel_shift_clock;
        ln_q = line_sync_pulse;
        fr_q = frame_sync_pulse;
        bus_q = panel_pixel_bus;
    end
endmodule

// >>> verif/test_passive_panel_line_timing.sv
module test_passive_panel_line_timing
    import panel_timing_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic [ADDR_W-1:0] address = 5'h00;
    logic read = 1'h0;
    logic write = 1'h0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic source_clock = 1'h0;
    logic [PIX_W-1:0] pix_data = 8'h5A;
    logic [PIX_W-1:0] step = 8'h01;
    logic pix_valid = 1'h0;
    logic pix_ready, frame_sync_pulse, line_sync_pulse, pixel_shift_clock;
    logic [PIX_W-1:0] panel_pixel_bus;
    logic panel_ac_bias, ac_bias_alias;
    logic [2:0] ctrl = 3'h0;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int t_last = 0;
    logic sh_d = 1'h0;

    passive_panel_line_timing dut_u (
        .clk(clk),
        .rstn(rstn),
        .address(address),
        .read(read),
        .write(write),
        .writedata(writedata),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .source_clock(source_clock),
        .pix_data(pix_data),
        .pix_valid(pix_valid),
        .pix_ready(pix_ready),
        .frame_sync_pulse(frame_sync_pulse),
        .line_sync_pulse(line_sync_pulse),
        .pixel_shift_clock(pixel_shift_clock),
        .panel_pixel_bus(panel_pixel_bus),
        .panel_ac_bias(panel_ac_bias),
        .ac_bias_alias(ac_bias_alias)
    );

    panel_model model_u (
        .clk(clk),
        .line_sync_pulse(line_sync_pulse),
        .frame_sync_pulse(frame_sync_pulse),
        .pixel_shift_clock(pixel_shift_clock),
        .panel_pixel_bus(panel_pixel_bus),
        .colour(ctrl[1])
    );

    always #25 clk = ~clk;
    // phase offset keeps source edges 12 ns after a system clock rise, off its edges
    initial begin
        #37;
        forever #200 source_clock = ~source_clock;
    end
    // pixel source: a new word after every accepted one
    always @(posedge clk) begin
        if (pix_valid && pix_ready) pix_data <= pix_data + step;
        cyc <= cyc + 1;
        if (sh_d && !pixel_shift_clock) t_last <= cyc;
        sh_d <= pixel_shift_clock;
        if (cyc == 20000) begin
            errors++;
            give_verdict;
        end
    end

    task give_verdict;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task chk_time(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            errors++;
            $display("wrong value at %0t: took %0d want %0d", $time, got, exp);
        end
    endtask

    task bus_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
                  output logic [31:0] q);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clk);
    endtask

    task wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_xfer(1'b1, a, d, q);
    endtask

    task rd(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus_xfer(1'b0, a, 32'h0, q);
        chk_val(q, exp);
    endtask

    // 0 line, 1 frame, 2 shift, 3 ac bias; t is the cycle it was seen
    task wait_sig(input int which, input logic lvl, output int t);
        logic s;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            case (which)
                0: s = line_sync_pulse;
                1: s = frame_sync_pulse;
                2: s = pixel_shift_clock;
                default: s = panel_ac_bias;
            endcase
            n++;
        end while (s !== lvl && n < 5000);
        t = cyc;
    endtask

    task edge_to(input int which, input logic lvl, output int t);
        wait_sig(which, !lvl, t);
        wait_sig(which, lvl, t);
    endtask

    task test_regs;
        rd(OFS_CTRL, 32'h0);
        rd(OFS_MOD, 32'h0);
        wr(OFS_HWIDTH, 32'hFFFFFFFF);
        rd(OFS_HWIDTH, 32'h00001F7F);
        wr(OFS_VCOUNT, 32'hFFFFFFFF);
        rd(OFS_VCOUNT, 32'h003F03FF);
        wr(5'h14, 32'hFFFFFFFF);
        rd(5'h14, 32'h0);
        // active width 1, blank width 3: a 48 Ts line, 2 active + 1 blank
        wr(OFS_HWIDTH, 32'h00000301);
        wr(OFS_VCOUNT, 32'h00000001);
        rd(OFS_HWIDTH, 32'h00000301);
    endtask

    task test_buffer;
        pix_valid <= 1'b1;
        repeat (10) @(posedge clk);
        chk_val(pix_ready, 32'h0);
    endtask

    task run_mode(input logic [2:0] c, input int rise, input int fall);
        int ta, tr, tf, tr2, tf2, tlr, tb, k;
        step <= c[1] ? 8'h10 : 8'h01;
        ctrl <= c;
        wr(OFS_CTRL, {29'h0, c});
        edge_to(0, 1'b1, tlr);
        edge_to(0, 1'b0, ta);
        edge_to(2, 1'b1, tr);
        edge_to(2, 1'b0, tf);
        edge_to(2, 1'b1, tr2);
        edge_to(2, 1'b0, tf2);
        chk_time(tr - ta, rise);
        chk_time(tf - ta, fall);
        chk_time(tr2 - tr, c[1] ? 8 : 64);
        chk_time(tf - tr, c[1] ? 4 : 32);
        edge_to(0, 1'b1, tlr);
        edge_to(0, 1'b0, tb);
        chk_time(tb - ta, 48 * 8);
        k = model_u.n_cap - 2;
        // a mono line here has two pixels, so the second fall is the last
        if (!c[1]) begin
            chk_time(tlr - tf2, c[2] ? 72 : 56);
            chk_time(tb - tf2, c[2] ? 160 : 144);
            chk_val(model_u.cap[k + 1], 8'(model_u.cap[k] + 8'h01));
        end else begin
            chk_time(tlr - t_last, c[2] ? 52 : 36);
            chk_time(tb - t_last, c[2] ? 140 : 124);
            chk_val(model_u.cap[k] & 8'h0F, 32'h0);
            chk_val(model_u.cap[k + 1], 8'(model_u.cap[k] + 8'h10));
        end
        wr(OFS_CTRL, 32'h0);
    endtask

    task test_frame_ac;
        int t0, t1, t2;
        // the full buffer held its words while the panel was idle
        chk_val(model_u.cap[0], 32'h5A);
        chk_val(model_u.cap[1], 32'h5B);
        ctrl <= 3'h1;
        wr(OFS_CTRL, 32'h1);
        edge_to(1, 1'b1, t0);
        edge_to(0, 1'b0, t1);
        wait_sig(1, 1'b0, t2);
        chk_time(t1 - t0, (48 - 12) * 8);
        chk_time(t2 - t1, 12 * 8);
        edge_to(1, 1'b1, t0);
        repeat (2) @(posedge clk);
        chk_val(model_u.frame_lines, 32'h3);
        edge_to(0, 1'b0, t1);
        wait_sig(3, !panel_ac_bias, t2);
        chk_time(t2 - t1, 3 * 8);
        chk_val(ac_bias_alias, panel_ac_bias);
        wr(OFS_MOD, 32'h1);
        edge_to(0, 1'b0, t1);
        wait_sig(3, !panel_ac_bias, t2);
        chk_time(t2 - t1, 35 * 8);
        edge_to(0, 1'b0, t1);
        wr(OFS_CTRL, 32'h0);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        test_regs;
        test_buffer;
        run_mode(3'h1, 144, 176);
        run_mode(3'h5, 128, 160);
        run_mode(3'h3, 152, 156);
        run_mode(3'h7, 136, 140);
        test_frame_ac;
        chk_val(model_u.errs, 32'h0);
        give_verdict;
    end
endmodule
